//--- rtl/ebps_pkg.sv
package ebps_pkg;

  // ---------------------------------------------------------------
  // Pin group widths and packing of the general-purpose port vector
  // ---------------------------------------------------------------
  localparam int AD_W = 16;
  localparam int LO_W = 15;
  localparam int HI_W = 6;
  localparam int CTL_W = 6;
  localparam int ADDR_W = 22;
  localparam int GP_W = AD_W + LO_W + HI_W + CTL_W;
  localparam int GP_AD_BASE = 0;
  localparam int GP_LO_BASE = GP_AD_BASE + AD_W;
  localparam int GP_HI_BASE = GP_LO_BASE + LO_W;
  localparam int GP_CTL_BASE = GP_HI_BASE + HI_W;

  // ---------------------------------------------------------------
  // Bit positions inside the control pin group
  // ---------------------------------------------------------------
  localparam int CTL_LOW_BYTE = 0;
  localparam int CTL_HIGH_BYTE = 1;
  localparam int CTL_RW_WRH = 2;
  localparam int CTL_DATA_STROBE = 3;
  localparam int CTL_ADDR_STROBE = 4;
  localparam int CTL_HOLD_GRANT = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] HELD_ADDR_RST = 22'h000000;
  localparam logic [1:0] HELD_BE_RST = 2'h3;
  localparam logic [AD_W-1:0] DATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Bus sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    EBPS_IDLE = 7'h01,
    EBPS_T1 = 7'h02,
    EBPS_T2 = 7'h04,
    EBPS_TW = 7'h08,
    EBPS_T3 = 7'h10,
    EBPS_HOLD = 7'h20,
    EBPS_STOP = 7'h40
  } ebps_state_t;

endpackage : ebps_pkg

//--- rtl/ebps_pin_cell.sv
`timescale 1ns/1ps
module ebps_pin_cell #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Function select and values
  input wire logic bus_sel_in,
  input wire logic [W-1:0] bus_val_in,
  input wire logic [W-1:0] bus_oe_in,
  input wire logic [W-1:0] gp_dir_in,
  input wire logic [W-1:0] gp_val_in,
  // Pin
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out,
  output logic [W-1:0] pin_read_out
);

  logic [W-1:0] next_pin;
  logic [W-1:0] next_oe;

  // Bus function or per-bit port function, each bit with its own direction.
  always_comb begin
    next_pin = bus_sel_in ? bus_val_in : gp_val_in;
    next_oe = bus_sel_in ? bus_oe_in : gp_dir_in;
  end

  // Drivers are released while reset is applied.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_out <= '0;
      pin_read_out <= '0;
    end else begin
      pin_out <= next_pin;
      pin_oe_out <= next_oe;
      pin_read_out <= pin_in;
    end
  end

endmodule : ebps_pin_cell

//--- rtl/ebps_clk_out.sv
`timescale 1ns/1ps
module ebps_clk_out (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  // Clock pin
  output logic clk_pin_out,
  output logic clk_oe_out
);

  logic next_clk;

  // Divide by two while running, otherwise hold low.
  always_comb begin
    next_clk = run_in ? ~clk_pin_out : 1'b0;
  end

  // The pin floats only while reset is applied.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_pin_out <= 1'b0;
      clk_oe_out <= 1'b0;
    end else begin
      clk_pin_out <= next_clk;
      clk_oe_out <= 1'b1;
    end
  end

endmodule : ebps_clk_out

//--- rtl/ebps_top.sv
// How it works
// - Reset floats pins; afterwards ports act as inputs.
// - Address/data lines float outside active bus cycles.
// - Halt holds address, strobes high, hold works.
// - Stop floats upper pins, clock low, ignore hold.
// - Hold grant low, upper pins float, requester holds.
// - Inactive cycle holds address, drives strobes high.
// - Inactive when expansion on and fetching internally.
// - Held levels undefined before first external access.
// - Held levels equal last external bus cycle.
// - Clock output low when inhibit is selected.
// - Wait ignored outside active bus cycle states.
// - Unused bus pins are per-bit directional ports.
// - Wait input inserts wait states into cycles.
// - Separate byte enables or byte write strobes.
// - Address from lower lines plus six upper.
// - Address in first state, data later, floats idle.
`timescale 1ns/1ps
module ebps_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Operating mode
  input wire logic expansion_mode_in,
  input wire logic pc_internal_in,
  input wire logic halt_in,
  input wire logic idle_stop_in,
  input wire logic system_clock_out_inhibit_in,
  input wire logic byte_strobe_sel_in,
  // Access request from the core
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [21:0] req_addr_in,
  input wire logic [1:0] req_be_n_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_done_out,
  output logic [15:0] req_rdata_out,
  output logic bus_inactive_out,
  output logic held_valid_out,
  // General-purpose port configuration and readback
  input wire logic [42:0] gp_dir_in,
  input wire logic [42:0] gp_val_in,
  output logic [42:0] gp_read_out,
  // Multiplexed address/data pins
  input wire logic [15:0] muxed_addr_data_in,
  output logic [15:0] muxed_addr_data_out,
  output logic [15:0] muxed_addr_data_oe_out,
  // Address pins
  input wire logic [14:0] lower_addr_lines_in,
  output logic [14:0] lower_addr_lines_out,
  output logic [14:0] lower_addr_lines_oe_out,
  input wire logic [5:0] upper_addr_lines_in,
  output logic [5:0] upper_addr_lines_out,
  output logic [5:0] upper_addr_lines_oe_out,
  // Control pins: byte enables, read/write, strobes, hold grant
  input wire logic [5:0] bus_ctl_in,
  output logic [5:0] bus_ctl_out,
  output logic [5:0] bus_ctl_oe_out,
  // Hold request, wait and clock output
  input wire logic bus_hold_request_n_in,
  input wire logic wait_in,
  output logic system_clock_out,
  output logic system_clock_oe_out
);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  ebps_pkg::ebps_state_t state, next_state;
  logic cyc_write, next_cyc_write, held_valid, next_held_valid, next_done, next_inactive, start;
  logic [15:0] cyc_wdata, next_cyc_wdata, next_rdata;
  logic [21:0] held_addr, next_held_addr;
  logic [1:0] held_be_n, next_held_be_n;
  logic st_idle, st_t1, st_data, st_hold, st_stop;

  assign st_idle = (state == ebps_pkg::EBPS_IDLE);
  assign st_t1 = (state == ebps_pkg::EBPS_T1);
  assign st_data = (state == ebps_pkg::EBPS_T2) || (state == ebps_pkg::EBPS_TW);
  assign st_hold = (state == ebps_pkg::EBPS_HOLD);
  assign st_stop = (state == ebps_pkg::EBPS_STOP);
  assign start = st_idle && expansion_mode_in && !idle_stop_in && bus_hold_request_n_in
    && req_valid_in && !halt_in;

  // Next state and cycle bookkeeping.
  always_comb begin
    next_state = state;
    next_cyc_write = cyc_write;
    next_cyc_wdata = cyc_wdata;
    next_held_addr = held_addr;
    next_held_be_n = held_be_n;
    next_held_valid = held_valid;
    next_rdata = req_rdata_out;
    next_done = 1'b0;
    case (state)
      ebps_pkg::EBPS_IDLE: begin
        if (idle_stop_in) begin
          next_state = ebps_pkg::EBPS_STOP;
        end else if (expansion_mode_in && !bus_hold_request_n_in) begin
          next_state = ebps_pkg::EBPS_HOLD;
        end else if (start) begin
          next_state = ebps_pkg::EBPS_T1;
          next_cyc_write = req_write_in;
          next_cyc_wdata = req_wdata_in;
          next_held_addr = req_addr_in;
          next_held_be_n = req_be_n_in;
          next_held_valid = 1'b1;
        end
      end
      ebps_pkg::EBPS_T1: begin
        next_state = ebps_pkg::EBPS_T2;
      end
      ebps_pkg::EBPS_T2, ebps_pkg::EBPS_TW: begin
        next_state = wait_in ? ebps_pkg::EBPS_TW : ebps_pkg::EBPS_T3;
      end
      ebps_pkg::EBPS_T3: begin
        next_state = ebps_pkg::EBPS_IDLE;
        next_done = 1'b1;
        // Pins lag the state by one edge, so read data stand on the bus from the state after T2 up to T3.
        if (!cyc_write) begin
          next_rdata = muxed_addr_data_in;
        end
      end
      ebps_pkg::EBPS_HOLD: begin
        if (bus_hold_request_n_in || !expansion_mode_in) begin
          next_state = ebps_pkg::EBPS_IDLE;
        end
      end
      ebps_pkg::EBPS_STOP: begin
        if (!idle_stop_in) begin
          next_state = ebps_pkg::EBPS_IDLE;
        end
      end
      default: begin
        next_state = ebps_pkg::EBPS_IDLE;
      end
    endcase
    if (!expansion_mode_in) begin
      next_held_valid = 1'b0;
    end
    next_inactive = expansion_mode_in && pc_internal_in && st_idle;
  end

  // Sequencer registers.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ebps_pkg::EBPS_IDLE;
      cyc_write <= 1'b0;
      cyc_wdata <= ebps_pkg::DATA_RST;
      held_addr <= ebps_pkg::HELD_ADDR_RST;
      held_be_n <= ebps_pkg::HELD_BE_RST;
      held_valid <= 1'b0;
      req_rdata_out <= ebps_pkg::DATA_RST;
      req_done_out <= 1'b0;
      bus_inactive_out <= 1'b0;
      held_valid_out <= 1'b0;
    end else begin
      state <= next_state;
      cyc_write <= next_cyc_write;
      cyc_wdata <= next_cyc_wdata;
      held_addr <= next_held_addr;
      held_be_n <= next_held_be_n;
      held_valid <= next_held_valid;
      req_rdata_out <= next_rdata;
      req_done_out <= next_done;
      bus_inactive_out <= next_inactive;
      held_valid_out <= next_held_valid;
    end
  end

  // ---------------------------------------------------------------
  // Bus-function pin values
  // ---------------------------------------------------------------
  logic [15:0] ad_val, ad_oe;
  logic [5:0] ctl_val, ctl_oe;
  logic wr_phase, upper_drive;

  // Strobes are active low; every strobe rests high between cycles.
  always_comb begin
    wr_phase = cyc_write && st_data;
    upper_drive = !(st_stop || st_hold);
    ad_val = st_t1 ? held_addr[15:0] : cyc_wdata;
    ad_oe = {16{st_t1 || (cyc_write && (st_data || state == ebps_pkg::EBPS_T3))}};
    ctl_val = '1;
    ctl_val[ebps_pkg::CTL_ADDR_STROBE] = !st_t1;
    ctl_val[ebps_pkg::CTL_DATA_STROBE] = !st_data;
    ctl_val[ebps_pkg::CTL_HIGH_BYTE] = held_be_n[1];
    if (byte_strobe_sel_in) begin
      ctl_val[ebps_pkg::CTL_LOW_BYTE] = !(wr_phase && !held_be_n[0]);
      ctl_val[ebps_pkg::CTL_RW_WRH] = !(wr_phase && !held_be_n[1]);
    end else begin
      ctl_val[ebps_pkg::CTL_LOW_BYTE] = held_be_n[0];
      ctl_val[ebps_pkg::CTL_RW_WRH] = !(cyc_write && !st_idle && !st_hold && !st_stop);
    end
    ctl_val[ebps_pkg::CTL_HOLD_GRANT] = !st_hold;
    ctl_oe = {6{upper_drive}};
    ctl_oe[ebps_pkg::CTL_HOLD_GRANT] = !st_stop;
  end

  // ---------------------------------------------------------------
  // Pin cells, one per group
  // ---------------------------------------------------------------
  ebps_pin_cell #(.W(ebps_pkg::AD_W)) u_ad (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus_sel_in(expansion_mode_in),
    .bus_val_in(ad_val),
    .bus_oe_in(ad_oe),
    .gp_dir_in(gp_dir_in[ebps_pkg::GP_AD_BASE +: ebps_pkg::AD_W]),
    .gp_val_in(gp_val_in[ebps_pkg::GP_AD_BASE +: ebps_pkg::AD_W]),
    .pin_in(muxed_addr_data_in),
    .pin_out(muxed_addr_data_out),
    .pin_oe_out(muxed_addr_data_oe_out),
    .pin_read_out(gp_read_out[ebps_pkg::GP_AD_BASE +: ebps_pkg::AD_W])
  );
  // Lower address lines stay driven in every bus-mode state.
  ebps_pin_cell #(.W(ebps_pkg::LO_W)) u_lo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus_sel_in(expansion_mode_in),
    .bus_val_in(held_addr[15:1]),
    .bus_oe_in({15{1'b1}}),
    .gp_dir_in(gp_dir_in[ebps_pkg::GP_LO_BASE +: ebps_pkg::LO_W]),
    .gp_val_in(gp_val_in[ebps_pkg::GP_LO_BASE +: ebps_pkg::LO_W]),
    .pin_in(lower_addr_lines_in),
    .pin_out(lower_addr_lines_out),
    .pin_oe_out(lower_addr_lines_oe_out),
    .pin_read_out(gp_read_out[ebps_pkg::GP_LO_BASE +: ebps_pkg::LO_W])
  );
  ebps_pin_cell #(.W(ebps_pkg::HI_W)) u_hi (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus_sel_in(expansion_mode_in),
    .bus_val_in(held_addr[21:16]),
    .bus_oe_in({6{upper_drive}}),
    .gp_dir_in(gp_dir_in[ebps_pkg::GP_HI_BASE +: ebps_pkg::HI_W]),
    .gp_val_in(gp_val_in[ebps_pkg::GP_HI_BASE +: ebps_pkg::HI_W]),
    .pin_in(upper_addr_lines_in),
    .pin_out(upper_addr_lines_out),
    .pin_oe_out(upper_addr_lines_oe_out),
    .pin_read_out(gp_read_out[ebps_pkg::GP_HI_BASE +: ebps_pkg::HI_W])
  );
  ebps_pin_cell #(.W(ebps_pkg::CTL_W)) u_ctl (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus_sel_in(expansion_mode_in),
    .bus_val_in(ctl_val),
    .bus_oe_in(ctl_oe),
    .gp_dir_in(gp_dir_in[ebps_pkg::GP_CTL_BASE +: ebps_pkg::CTL_W]),
    .gp_val_in(gp_val_in[ebps_pkg::GP_CTL_BASE +: ebps_pkg::CTL_W]),
    .pin_in(bus_ctl_in),
    .pin_out(bus_ctl_out),
    .pin_oe_out(bus_ctl_oe_out),
    .pin_read_out(gp_read_out[ebps_pkg::GP_CTL_BASE +: ebps_pkg::CTL_W])
  );

  // Clock output runs except in stop mode or under inhibit.
  ebps_clk_out u_clk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(!st_stop && !system_clock_out_inhibit_in),
    .clk_pin_out(system_clock_out),
    .clk_oe_out(system_clock_oe_out)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_addr_phase;
    st_t1 ##1 st_data;
  endsequence

  property p_cycle_order;
    start |=> s_addr_phase;
  endproperty
  a_cycle_order: assert property (p_cycle_order) else $error("Cycle did not go T1 then T2.");

  property p_ad_float;
    (expansion_mode_in && st_idle) |=> (muxed_addr_data_oe_out == 16'h0000);
  endproperty
  a_ad_float: assert property (p_ad_float) else $error("Address/data driven while idle.");

  property p_stop_pins;
    (expansion_mode_in && st_stop) |=> (upper_addr_lines_oe_out == 6'h00) && (bus_ctl_oe_out == 6'h00);
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("Pins driven in stop mode.");

  property p_stop_clock;
    st_stop [*2] |=> !system_clock_out;
  endproperty
  a_stop_clock: assert property (p_stop_clock) else $error("Clock output running in stop mode.");

  property p_hold_grant;
    (expansion_mode_in && st_hold) |=> !bus_ctl_out[ebps_pkg::CTL_HOLD_GRANT]
      && bus_ctl_oe_out[ebps_pkg::CTL_HOLD_GRANT] && (upper_addr_lines_oe_out == 6'h00);
  endproperty
  a_hold_grant: assert property (p_hold_grant) else $error("Hold grant not driven low.");

  property p_wait_stretch;
    (st_data && wait_in) |=> (state == ebps_pkg::EBPS_TW);
  endproperty
  a_wait_stretch: assert property (p_wait_stretch) else $error("Wait state not inserted.");

  property p_wait_ignored;
    (!st_data) |=> (state != ebps_pkg::EBPS_TW);
  endproperty
  a_wait_ignored: assert property (p_wait_ignored) else $error("Wait acted on outside data phase.");

  property p_held_stable;
    (st_idle && $past(st_idle) && held_valid) |-> (held_addr == $past(held_addr));
  endproperty
  a_held_stable: assert property (p_held_stable) else $error("Held address changed between cycles.");

  property p_held_cleared;
    !expansion_mode_in |=> !held_valid_out;
  endproperty
  a_held_cleared: assert property (p_held_cleared) else $error("Held flag kept after expansion off.");

  property p_inactive;
    (expansion_mode_in && pc_internal_in && st_idle) |=> bus_inactive_out;
  endproperty
  a_inactive: assert property (p_inactive) else $error("Inactive condition not flagged.");

  property p_idle_strobes;
    (expansion_mode_in && st_idle && !byte_strobe_sel_in) |=> bus_ctl_out[ebps_pkg::CTL_DATA_STROBE]
      && bus_ctl_out[ebps_pkg::CTL_ADDR_STROBE] && bus_ctl_out[ebps_pkg::CTL_RW_WRH];
  endproperty
  a_idle_strobes: assert property (p_idle_strobes) else $error("Strobes not high while idle.");

  property p_inhibit;
    system_clock_out_inhibit_in [*2] |=> !system_clock_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Clock output running under inhibit.");

endmodule : ebps_top

//--- testbench/ebps_ext_mem.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External memory and bus hold requester
// ---------------------------------------------------------------
module ebps_ext_mem (
  // Clock
  input wire logic clk_in,
  // Bus wire levels
  input wire logic [15:0] ad_in,
  input wire logic [5:0] ctl_in,
  input wire logic strobe_sel_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  // Scenario controls
  input wire logic [3:0] wait_n_in,
  input wire logic hold_want_in,
  output logic wait_out,
  output logic hold_req_n_out
);
  logic [15:0] mem [16];
  logic [3:0] idx;
  logic [3:0] cnt = 4'h0;
  logic addr_strobe_out_q;
  logic start;
  logic wr_lo;
  logic wr_hi;
  // Decode the strobes of both pin modes; memory drives only while a read strobe is low.
  assign start = !ctl_in[4] && addr_strobe_out_q;
  assign wr_lo = strobe_sel_in ? !ctl_in[0] : (!ctl_in[2] && !ctl_in[0]);
  assign wr_hi = strobe_sel_in ? !ctl_in[2] : (!ctl_in[2] && !ctl_in[1]);
  assign data_oe_out = !ctl_in[3] && !wr_lo && !wr_hi;
  assign data_out = mem[idx];
  // A slow device stretches every access by the commanded number of waits.
  assign wait_out = (wait_n_in != 4'h0) && (start || cnt != 4'h0);
  // The requester keeps its request low for as long as it wants the bus.
  assign hold_req_n_out = !hold_want_in;
  // Latch the address at the strobe, count waits and store written lanes.
  always @(posedge clk_in) begin
    addr_strobe_out_q <= ctl_in[4];
    if (start) begin
      idx <= ad_in[4:1];
      cnt <= (wait_n_in == 4'h0) ? 4'h0 : wait_n_in - 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    if (!ctl_in[3] && wr_lo) mem[idx][7:0] <= ad_in[7:0];
    if (!ctl_in[3] && wr_hi) mem[idx][15:8] <= ad_in[15:8];
  end
endmodule : ebps_ext_mem

//--- testbench/ebps_top_tb.sv
`timescale 1ns/1ps
module ebps_top_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_in, rst_in, exp_m, pc_int, halt, stop, inhibit, sel, rv, rw, done, inact, hvalid;
  logic [21:0] ra;
  logic [1:0] rbe;
  logic [15:0] rwd, rdata, ad_in, ad_out, ad_oe, ext_ad, m_d;
  logic [42:0] dir, val, gread, ext;
  logic [14:0] lo_in, lo_out, lo_oe, ext_lo;
  logic [5:0] hi_in, hi_out, hi_oe, ext_hi, ctl_in, ctl_out, ctl_oe, ext_ctl;
  logic m_oe, hold_n, wt, ck, ck_oe, hold_want;
  logic [3:0] wn;
  int n_mismatch, tests_run;
  localparam logic [21:0] A = 22'h2aa556;
  localparam logic [21:0] B = 22'h15aaa8;
  // Each wire shows its driver, or the level the bench puts there when nobody drives it.
  assign {ext_ctl, ext_hi, ext_lo, ext_ad} = ext;
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & (m_oe ? m_d : ext_ad));
  assign lo_in = (lo_oe & lo_out) | (~lo_oe & ext_lo);
  assign hi_in = (hi_oe & hi_out) | (~hi_oe & ext_hi);
  assign ctl_in = (ctl_oe & ctl_out) | (~ctl_oe & ext_ctl);
  ebps_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .expansion_mode_in(exp_m), .pc_internal_in(pc_int),
    .halt_in(halt), .idle_stop_in(stop), .system_clock_out_inhibit_in(inhibit), .byte_strobe_sel_in(sel),
    .req_valid_in(rv), .req_write_in(rw), .req_addr_in(ra), .req_be_n_in(rbe), .req_wdata_in(rwd),
    .req_done_out(done), .req_rdata_out(rdata), .bus_inactive_out(inact), .held_valid_out(hvalid),
    .gp_dir_in(dir), .gp_val_in(val), .gp_read_out(gread), .muxed_addr_data_in(ad_in),
    .muxed_addr_data_out(ad_out), .muxed_addr_data_oe_out(ad_oe), .lower_addr_lines_in(lo_in),
    .lower_addr_lines_out(lo_out), .lower_addr_lines_oe_out(lo_oe), .upper_addr_lines_in(hi_in),
    .upper_addr_lines_out(hi_out), .upper_addr_lines_oe_out(hi_oe), .bus_ctl_in(ctl_in),
    .bus_ctl_out(ctl_out), .bus_ctl_oe_out(ctl_oe), .bus_hold_request_n_in(hold_n), .wait_in(wt),
    .system_clock_out(ck), .system_clock_oe_out(ck_oe));
  ebps_ext_mem mem_u (.clk_in(clk_in), .ad_in(ad_in), .ctl_in(ctl_in), .strobe_sel_in(sel),
    .data_out(m_d), .data_oe_out(m_oe), .wait_n_in(wn), .hold_want_in(hold_want), .wait_out(wt),
    .hold_req_n_out(hold_n));
  // Free-running system clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // One external access held until done, with its latency judged.
  task acc(input logic w, input logic [21:0] a, input logic [1:0] be, input logic [15:0] d, input int waits);
    int n;
    tick(1);
    n = 0;
    wn = waits[3:0];
    rw = w;
    ra = a;
    rbe = be;
    rwd = d;
    rv = 1'b1;
    do begin
      tick(1);
      n++;
    end while (done !== 1'b1 && n < 40);
    rv = 1'b0;
    chk("latency", n, 4 + waits);
    if (n >= 40) final_report();
  endtask : acc
  task held(input logic [21:0] a, input logic [1:0] be, input logic full);
    chk("lower", {lo_oe, lo_out}, {15'h7fff, a[15:1]});
    if (full) chk("upper", {hi_oe, hi_out, ctl_oe[1:0], ctl_out[1:0]}, {6'h3f, a[21:16], 2'h3, be});
    chk("ad_float", ad_oe, 16'h0);
  endtask : held
  task strb;
    chk("strobes", {ctl_oe[4:2], ctl_out[4:2]}, 6'h3f);
  endtask : strb
  task clkc(input logic run);
    logic p;
    for (int i = 0; i < 4; i++) begin
      p = ck;
      tick(1);
      chk("system_clock_out", {ck_oe, ck}, {1'b1, run ? ~p : 1'b0});
    end
  endtask : clkc
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    tick(3);
    chk("reset_oe", {ctl_oe, hi_oe, lo_oe, ad_oe, ck_oe}, 44'h0);
    tick(3);
    rst_in = 1'b0;
    tick(2);
    chk("port_in", {ctl_oe, hi_oe, lo_oe, ad_oe}, 43'h0);
    chk("clk_oe", ck_oe, 1'b1);
  endtask : t_reset
  task t_port;
    dir = 43'h2a5_a5a5_a5a5;
    val = 43'h1c3_3c3c_3c3c;
    tick(3);
    chk("port_oe", {ctl_oe, hi_oe, lo_oe, ad_oe}, dir);
    chk("port_out", {ctl_out, hi_out, lo_out, ad_out} & dir, val & dir);
    chk("port_read", gread, (dir & val) | (~dir & ext));
    dir = 43'h0;
  endtask : t_port
  task t_access;
    exp_m = 1'b1;
    tick(2);
    chk("held_valid", hvalid, 1'b0);
    acc(1'b1, A, 2'h0, 16'h1234, 0);
    // The pins still show the last bus state for one more edge.
    tick(1);
    held(A, 2'h0, 1'b1);
    strb();
    chk("held_valid", hvalid, 1'b1);
    acc(1'b1, B, 2'h0, 16'hbeef, 2);
    acc(1'b1, A, 2'h2, 16'h00cd, 1);
    sel = 1'b1;
    acc(1'b1, A, 2'h1, 16'hab00, 0);
    acc(0, B, 2'h0, 16'h0, 2);
    chk("rdata_b", rdata, 16'hbeef);
    acc(0, A, 2'h0, 16'h0, 3);
    chk("rdata_a", rdata, 16'habcd);
    acc(0, A, 2'h0, 16'h0, 0);
    chk("rdata_a0", rdata, 16'habcd);
    sel = 1'b0;
  endtask : t_access
  task t_inactive;
    pc_int = 1'b1;
    tick(3);
    chk("inactive", inact, 1'b1);
    held(A, 2'h0, 1'b1);
    strb();
    clkc(1'b1);
    inhibit = 1'b1;
    clkc(1'b0);
    inhibit = 1'b0;
    pc_int = 1'b0;
    tick(2);
    chk("active", inact, 1'b0);
  endtask : t_inactive
  task t_halt_hold;
    halt = 1'b1;
    tick(2);
    held(A, 2'h0, 1'b1);
    strb();
    clkc(1'b1);
    hold_want = 1'b1;
    tick(4);
    chk("grant", {ctl_oe, ctl_out[5], hi_oe}, 13'h1000);
    held(A, 2'h0, 1'b0);
    hold_want = 1'b0;
    tick(3);
    chk("ungrant", {ctl_oe[5], ctl_out[5]}, 2'h3);
    halt = 1'b0;
  endtask : t_halt_hold
  task t_stop;
    stop = 1'b1;
    hold_want = 1'b1;
    tick(3);
    chk("stop_float", {hi_oe, ctl_oe}, 12'h0);
    held(A, 2'h0, 1'b0);
    clkc(1'b0);
    hold_want = 1'b0;
    stop = 1'b0;
    exp_m = 1'b0;
    tick(2);
    exp_m = 1'b1;
    tick(2);
    chk("held_reset", hvalid, 1'b0);
  endtask : t_stop
  // Main sequence.
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    rst_in = 1'b1;
    {exp_m, pc_int, halt, stop, inhibit, sel, rv, rw, hold_want} = 9'h0;
    ra = 22'h0;
    rbe = 2'h3;
    rwd = 16'h0;
    wn = 4'h0;
    dir = 43'h0;
    val = 43'h0;
    ext = 43'h7e1_2345_6789;
    #1;
    t_reset();
    t_port();
    t_access();
    t_inactive();
    t_halt_hold();
    t_stop();
    final_report();
  end
endmodule : ebps_top_tb
